// ==== rtl/eeprom_bus_recovery_write_guard.v ====
// Protocol, recovery and write-guard logic of the two-wire EEPROM slave
`timescale 1ns/1ns
`include "eeprom_guard_map.vh"
module eeprom_bus_recovery_write_guard #(
  parameter [31:0] INIT_CYCLES  = `INIT_CYC,
  parameter [31:0] WRITE_CYCLES = `WRITE_CYC
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       low_supply,
  input  wire [7:0] rd_data,
  output reg        sda_out_q,
  output reg        sda_oe_q,
  output reg        ready_q,
  output reg        write_busy_q,
  output reg        write_start_q,
  output reg        write_cancel_q,
  output reg  [3:0] byte_count_q,
  output reg        cmd_cancel_q
);
  // Filter count is small; cut the 32-bit quotient to the counter width on purpose
  localparam [31:0] GLITCH_FULL  = `GLITCH_CYC;
  localparam [5:0]  GLITCH_LIMIT = GLITCH_FULL[5:0];

  // Protocol states
  localparam [2:0]  ST_IDLE      = 3'h0;
  localparam [2:0]  ST_ADDR      = 3'h1;
  localparam [2:0]  ST_ACK       = 3'h2;
  localparam [2:0]  ST_WDATA     = 3'h3;
  localparam [2:0]  ST_RDATA     = 3'h4;
  localparam [2:0]  ST_RACK      = 3'h5;
  localparam [2:0]  ST_SKIP      = 3'h6;

  wire       scl_f;
  wire       sda_f;
  reg        scl_prev_q;
  reg        sda_prev_q;
  reg        low_meta_q;
  reg        low_sync_q;
  reg  [2:0] state_q;
  reg  [2:0] bit_cnt_q;
  reg  [7:0] shift_q;
  reg        acked_q;
  reg  [7:0] tx_q;
  reg [31:0] timer_q;

  wire scl_rise = scl_f & ~scl_prev_q;
  wire scl_fall = ~scl_f & scl_prev_q;
  wire start_c  = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  wire stop_c   = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  ////////////////////////////////////////////////////////////////////////////

  // Both bus lines filtered the same way
  glitch_filter #(.CNT_W(6), .LIMIT(GLITCH_LIMIT)) u_scl_filt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (scl_in),
    .level_q (scl_f)
  );

  glitch_filter #(.CNT_W(6), .LIMIT(GLITCH_LIMIT)) u_sda_filt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (sda_in),
    .level_q (sda_f)
  );

  // Edge history and supply-detector synchroniser
  always @(posedge clk) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      low_meta_q <= 1'b0;
      low_sync_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
      low_meta_q <= low_supply;
      low_sync_q <= low_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on initialisation and write-cycle timer
  ////////////////////////////////////////////////////////////////////////////

  // One timer serves both: bus is deaf until it expires
  always @(posedge clk) begin
    if (sys_rst) begin
      timer_q      <= 32'h0000_0000;
      ready_q      <= 1'b0;
      write_busy_q <= 1'b0;
    end else if (!ready_q) begin
      if (timer_q >= INIT_CYCLES - 32'h0000_0001) begin
        ready_q <= 1'b1; // RL10
        timer_q <= 32'h0000_0000;
      end else begin
        timer_q <= timer_q + 32'h0000_0001;
      end
    end else if (write_start_q) begin
      write_busy_q <= 1'b1;
      timer_q      <= 32'h0000_0000;
    end else if (write_busy_q) begin
      if (timer_q >= WRITE_CYCLES - 32'h0000_0001) begin
        write_busy_q <= 1'b0;
        timer_q      <= 32'h0000_0000;
      end else begin
        timer_q <= timer_q + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  ////////////////////////////////////////////////////////////////////////////

  // Bits sampled on SCL rise, SDA changed on SCL fall
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q        <= ST_IDLE;
      bit_cnt_q      <= 3'h0;
      shift_q        <= 8'h00;
      acked_q        <= 1'b0;
      tx_q           <= 8'h00;
      byte_count_q   <= 4'h0;
      sda_out_q      <= 1'b1;
      sda_oe_q       <= 1'b0;
      write_start_q  <= 1'b0;
      write_cancel_q <= 1'b0;
      cmd_cancel_q   <= 1'b0;
    end else begin
      write_start_q  <= 1'b0;
      write_cancel_q <= 1'b0;
      cmd_cancel_q   <= 1'b0;
      if (!ready_q || write_busy_q) begin
        state_q      <= ST_IDLE; // RL9 RL16
        sda_oe_q     <= 1'b0;
        byte_count_q <= 4'h0;
      end else if (start_c) begin
        // Start wins over stop and every state, not over init or a write cycle: partial command dropped; its own SCL rise counts one bit
        cmd_cancel_q <= ((state_q == ST_ADDR) || (state_q == ST_WDATA)) && (bit_cnt_q > 3'h1); // RL13
        state_q      <= ST_ADDR; // RL17
        bit_cnt_q    <= 3'h0; // RL5
        shift_q      <= 8'h00;
        byte_count_q <= 4'h0;
        acked_q      <= 1'b0;
        sda_oe_q     <= 1'b0;
      end else if (stop_c) begin
        // The stop's own SCL rise shifts one bit, so a stop right after an acknowledge
        // shows one counted bit with the flag still up; the address byte alone never commits
        if (state_q == ST_WDATA && bit_cnt_q == 3'h1 && acked_q && byte_count_q > 4'h1) begin // RL12
          if (low_sync_q)
            write_cancel_q <= 1'b1; // RL1
          else
            write_start_q <= 1'b1;
        end
        state_q  <= ST_IDLE; // RL2
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_WDATA: begin
            if (scl_fall && acked_q)
              sda_oe_q <= 1'b0; // Release after acknowledge
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_f};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              // Flag survives the first rise after an acknowledge, which may be a stop
              acked_q   <= acked_q && (bit_cnt_q == 3'h0);
              if (bit_cnt_q == 3'h7)
                state_q <= ST_ACK;
            end
          end
          ST_ACK: begin
            // Drive acknowledge for one SCL period; state held meanwhile
            if (scl_fall && !sda_oe_q) begin
              if (byte_count_q == 4'h0 && shift_q[7:4] != `DEV_CODE) begin
                state_q <= ST_SKIP; // Not our address: stay off the bus
              end else begin
                sda_out_q <= 1'b0; // RL3
                sda_oe_q  <= 1'b1;
              end
            end else if (scl_fall && sda_oe_q) begin
              acked_q <= 1'b1;
              if (byte_count_q == 4'h0 && shift_q[0]) begin
                tx_q      <= rd_data;
                sda_out_q <= rd_data[7];
                sda_oe_q  <= ~rd_data[7];
                bit_cnt_q <= 3'h0;
                state_q   <= ST_RDATA;
              end else begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_WDATA;
              end
              if (byte_count_q != 4'hf)
                byte_count_q <= byte_count_q + 4'h1;
            end
          end
          ST_RDATA: begin
            // Open-drain: drive only zeros, a one releases the line
            if (scl_fall) begin
              if (bit_cnt_q == 3'h7) begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_RACK;
              end else begin
                tx_q      <= {tx_q[6:0], 1'b1};
                sda_out_q <= tx_q[6];
                sda_oe_q  <= ~tx_q[6]; // RL3
                bit_cnt_q <= bit_cnt_q + 3'h1;
              end
            end
          end
          ST_RACK: begin
            // Master nack ends the read; recovery pulses land here
            if (scl_rise && sda_f)
              state_q <= ST_SKIP; // RL4
            else if (scl_rise) begin
              tx_q      <= rd_data;
              bit_cnt_q <= 3'h0;
            end else if (scl_fall && bit_cnt_q == 3'h0 && sda_f == 1'b0) begin
              sda_out_q <= tx_q[7];
              sda_oe_q  <= ~tx_q[7];
              state_q   <= ST_RDATA;
            end
          end
          ST_SKIP: begin
            sda_oe_q <= 1'b0; // Wait passively for a start
          end
          default: begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // eeprom_bus_recovery_write_guard

// ==== inc/eeprom_guard_map.vh ====
// Constants of the two-wire slave recovery and write-guard logic
// Functional notes
// [RL1] At stop, abandon the pending write when the low-supply detector flags low supply.
// [RL2] No reset pin; a start followed by a stop returns the protocol to idle.
// [RL3] While the slave drives SDA low, the master cannot start or stop.
// [RL4] Master recovers with a start, then nine SCL pulses with SDA high.
// [RL5] After the dummy pulses a start resets the slave; a stop adds safety.
// [RL6] Master must start right after nine dummy pulses, or a stop may write.
// [RL7] Master should run the recovery sequence at system initialisation.
// [RL8] Master checks every acknowledge; a missing one is a failure.
// [RL9] No instruction is accepted during power-on initialisation.
// [RL10] After initialisation the slave stands by, idle, waiting for a start.
// [RL11] Without a guaranteed power-on-clear, the master runs the recovery sequence.
// [RL12] Write only after one or more full bytes and a stop right after acknowledge.
// [RL13] A start while a command shifts in cancels it and drops partial contents.
// [RL14] After a cancel the master treats the address pointer as undefined.
// [RL15] Pulses on SDA and SCL of 130 ns or less are suppressed.
// [RL16] While a write cycle runs, all bus traffic is ignored and not acknowledged.
// [RL17] After a start, the next eight bits are decoded as the device address.
`ifndef EEPROM_GUARD_MAP_VH
`define EEPROM_GUARD_MAP_VH
`define CLK_PERIOD_PS     32'd4000
`define GLITCH_TIME_NS    32'd130
`define GLITCH_CYC        ((`GLITCH_TIME_NS * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define INIT_TIME_US      32'd100
`define INIT_CYC          (`INIT_TIME_US * 32'd1000000 / `CLK_PERIOD_PS)
`define WRITE_TIME_US     32'd5000
`define WRITE_CYC         (`WRITE_TIME_US * 32'd1000000 / `CLK_PERIOD_PS)
`define DEV_CODE          4'ha
`endif

// ==== rtl/glitch_filter.v ====
// Two-stage synchroniser plus pulse-width filter for one bus line
`timescale 1ns/1ns
module glitch_filter #(
  parameter CNT_W = 6,
  parameter [CNT_W-1:0] LIMIT = 6'd33
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire pin_in,
  output reg  level_q
);
  reg             meta_q;
  reg             sync_q;
  reg [CNT_W-1:0] cnt_q;

  // Metastability guard: meta_q is read by sync_q only
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // New level must persist beyond the glitch window before it is believed
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_q   <= {CNT_W{1'b0}};
      level_q <= 1'b1;
    end else if (sync_q == level_q) begin
      cnt_q <= {CNT_W{1'b0}};
    end else if (cnt_q >= LIMIT) begin
      level_q <= sync_q; // RL15
      cnt_q   <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // glitch_filter

// ==== tb/bus_master_model.sv ====
// Two-wire bus master model
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic sda_wire,
  output logic      scl_o,
  output logic      sda_o
);
  // Both lines released at power-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////
  // SDA falls while SCL high, in 125 ns steps; SCL low lasts 250 ns so the filter keeps it
  task automatic start();
    #125 sda_o = 1'b1;
    #125 scl_o = 1'b1;
    #125 sda_o = 1'b0;
    #125 scl_o = 1'b0;
  endtask
  // SDA rises while SCL high, then bus free time
  task automatic stop();
    #125 sda_o = 1'b0;
    #125 scl_o = 1'b1;
    #125 sda_o = 1'b1;
    #250;
  endtask
  // One bit; g adds 100 ns spikes the slave must not see
  task automatic bit_io(input logic b, input logic g, output logic r);
    #125 sda_o = b;
    #125 scl_o = 1'b1;
    if (g) begin
      #50 sda_o = ~b;
      #100 sda_o = b;
    end
    #150 r = sda_wire;
    #125 scl_o = 1'b0;
    if (g) begin
      #50 scl_o = 1'b1;
      #100 scl_o = 1'b0;
    end
  endtask
  // Byte MSB first, then the acknowledge slot with SDA released
  task automatic send(input logic [7:0] d, input logic g, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], g && (i == 7), r);
    end
    bit_io(1'b1, 1'b0, ack);
  endtask
  // Byte read MSB first with SDA released, then a nack ends the read
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 1'b0, r);
      d[i] = r;
    end
    bit_io(1'b1, 1'b0, r);
  endtask
  // Start, nine dummy clocks with SDA high, start, stop
  task automatic recover();
    logic r;
    start();
    repeat (9) bit_io(1'b1, 1'b0, r);
    start();
    stop();
  endtask
endmodule // bus_master_model

// ==== tb/eeprom_guard_properties.sv ====
// Port checker of the write-guard slave
`timescale 1ns/1ns
module eeprom_guard_checker #(
  parameter [31:0] INIT_CYCLES  = 32'd50,
  parameter [31:0] WRITE_CYCLES = 32'd2000
) (
  input wire clk,
  input wire sys_rst,
  input wire sda_out_q,
  input wire sda_oe_q,
  input wire ready_q,
  input wire write_busy_q,
  input wire write_start_q,
  input wire write_cancel_q,
  input wire cmd_cancel_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Commit pulse ends and the write cycle holds
  sequence s_commit; (write_busy_q && !write_start_q) ##1 write_busy_q; endsequence
  sequence s_drop; !write_start_q ##1 !write_busy_q; endsequence
  sequence s_hold; sda_oe_q [*8]; endsequence
  property p_quiet_init; !ready_q |-> !sda_oe_q; endproperty
  property p_ready_hold; ready_q |=> ready_q; endproperty
  property p_standby; $rose(ready_q) |-> !sda_oe_q && !write_busy_q; endproperty
  property p_commit; write_start_q |=> s_commit; endproperty
  property p_drop; write_cancel_q |-> s_drop; endproperty
  property p_quiet_busy; write_busy_q |-> !sda_oe_q; endproperty
  property p_pull_low; sda_oe_q |-> !sda_out_q; endproperty
  property p_hold; $rose(sda_oe_q) |-> s_hold; endproperty
  property p_cancel; cmd_cancel_q |-> !sda_oe_q ##1 !cmd_cancel_q; endproperty
  a_quiet_init: assert property (p_quiet_init) else $error("SDA driven before init");
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  a_standby: assert property (p_standby) else $error("not idle at ready");
  a_commit: assert property (p_commit) else $error("commit without write cycle");
  a_drop: assert property (p_drop) else $error("write ran at low supply");
  a_quiet_busy: assert property (p_quiet_busy) else $error("answer during write");
  a_pull_low: assert property (p_pull_low) else $error("SDA driven high");
  a_hold: assert property (p_hold) else $error("SDA drive too short");
  a_cancel: assert property (p_cancel) else $error("bad cancel pulse");
endmodule // eeprom_guard_checker
bind eeprom_bus_recovery_write_guard eeprom_guard_checker #(
  .INIT_CYCLES(INIT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .ready_q(ready_q),
  .write_busy_q(write_busy_q), .write_start_q(write_start_q), .write_cancel_q(write_cancel_q),
  .cmd_cancel_q(cmd_cancel_q));

// ==== tb/tb_top.sv ====
// Self-checking bench of the write-guard slave
`timescale 1ns/1ns
module tb_top;
  logic       clk, sys_rst, low_supply, scl_o, sda_o, sda_wire, ack;
  logic [7:0] rd_data, rd_seen;
  logic       sda_out_q, sda_oe_q, ready_q, write_busy_q;
  logic       write_start_q, write_cancel_q, cmd_cancel_q;
  logic [3:0] byte_count_q;
  int         bad_count, samples_checked, n_wr, n_can, n_cmd, cyc, w, v;
  // Open-drain SDA with pull-up: low if either party pulls
  assign sda_wire = sda_o & ~(sda_oe_q & ~sda_out_q);
  eeprom_bus_recovery_write_guard #(.INIT_CYCLES(32'd50), .WRITE_CYCLES(32'd2000)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_o), .sda_in(sda_wire), .low_supply(low_supply),
    .rd_data(rd_data), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .ready_q(ready_q),
    .write_busy_q(write_busy_q), .write_start_q(write_start_q), .write_cancel_q(write_cancel_q),
    .byte_count_q(byte_count_q), .cmd_cancel_q(cmd_cancel_q));
  bus_master_model u_bm (.sda_wire(sda_wire), .scl_o(scl_o), .sda_o(sda_o));
  // 250 MHz clock
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // Pulse counters; hang limit far above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_wr <= n_wr + int'(write_start_q);
    n_can <= n_can + int'(write_cancel_q);
    n_cmd <= n_cmd + int'(cmd_cancel_q);
    if (cyc == 80000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_init();
    @(posedge clk);
    #1 check(ready_q, 1'b0);
    repeat (60) @(posedge clk);
    #1 check(ready_q, 1'b1);
    check(sda_oe_q, 1'b0);
    u_bm.recover();
    $display("init test done");
  endtask
  // Write commits, then traffic is ignored while it runs
  task automatic t_write();
    w = n_wr;
    u_bm.start();
    u_bm.send(8'ha0, 1'b1, ack);
    check(ack, 1'b0);
    u_bm.send(8'h5a, 1'b0, ack);
    check(ack, 1'b0);
    // Count steps on the filtered SCL fall, some 150 ns after the pin
    repeat (60) @(posedge clk);
    check(byte_count_q, 4'd2);
    u_bm.stop();
    check(n_wr - w, 1);
    check(write_busy_q, 1'b1);
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    check(ack, 1'b1);
    u_bm.stop();
    check(n_wr - w, 1);
    repeat (2100) @(posedge clk);
    $display("write test done");
  endtask
  task automatic t_low();
    w = n_can;
    v = n_wr;
    @(posedge clk) low_supply <= 1'b1;
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    u_bm.send(8'h33, 1'b0, ack);
    u_bm.stop();
    check(n_can - w, 1);
    check(n_wr - v, 0);
    check(write_busy_q, 1'b0);
    @(posedge clk) low_supply <= 1'b0;
    $display("low supply test done");
  endtask
  // Stops after the address only and in mid-byte start nothing
  task automatic t_nowrite();
    w = n_wr;
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    u_bm.stop();
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    repeat (4) u_bm.bit_io(1'b0, 1'b0, ack);
    u_bm.stop();
    check(n_wr - w, 0);
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    check(ack, 1'b0);
    u_bm.stop();
    $display("no write test done");
  endtask
  task automatic t_cancel();
    w = n_wr;
    v = n_cmd;
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    repeat (3) u_bm.bit_io(1'b1, 1'b0, ack);
    u_bm.start();
    repeat (60) @(posedge clk);
    check(n_cmd - v, 1);
    u_bm.send(8'ha0, 1'b0, ack);
    check(ack, 1'b0);
    repeat (60) @(posedge clk);
    check(byte_count_q, 4'd1);
    u_bm.send(8'h77, 1'b0, ack);
    u_bm.stop();
    check(n_wr - w, 1);
    repeat (2100) @(posedge clk);
    // Pointer unknown after the cancel: read back with an explicit address load
    @(posedge clk) rd_data <= 8'h5c;
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    u_bm.send(8'h10, 1'b0, ack);
    u_bm.start();
    u_bm.send(8'ha1, 1'b0, ack);
    check(ack, 1'b0);
    u_bm.recv(rd_seen);
    u_bm.stop();
    check(rd_seen, 8'h5c);
    check(n_wr - w, 1);
    @(posedge clk) rd_data <= 8'h00;
    $display("cancel test done");
  endtask
  // Slave stuck sending zeros; a start cannot get through
  task automatic t_recover();
    w = n_wr;
    u_bm.start();
    u_bm.send(8'ha1, 1'b0, ack);
    check(ack, 1'b0);
    repeat (2) u_bm.bit_io(1'b1, 1'b0, ack);
    check(ack, 1'b0);
    u_bm.start();
    check(sda_oe_q, 1'b1);
    u_bm.recover();
    check(sda_oe_q, 1'b0);
    check(n_wr - w, 0);
    u_bm.start();
    u_bm.send(8'ha0, 1'b0, ack);
    check(ack, 1'b0);
    u_bm.stop();
    $display("recovery test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    low_supply = 1'b0;
    rd_data = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_init();
    t_write();
    t_low();
    t_nowrite();
    t_cancel();
    t_recover();
    finish_test();
  end
endmodule // tb_top
